// ===== hdl/sti_pkg.sv
// shared constants and types for the stage 2 invalidation block
package sti_pkg;
  // command opcodes carried in word 0 bits [7:0]
  localparam logic [7:0] OP_S2_ADDR = 8'h2A;
  localparam logic [7:0] OP_SEC_S2_ADDR = 8'h5A;
  localparam logic [7:0] OP_NS_ALL = 8'h30;
  localparam int OPCODE_LSB = 0;
  localparam int OPCODE_W = 8;

  // field layout of words 1..3
  localparam int VM_TAG_LSB = 0;
  localparam int VM_TAG_W = 16;
  localparam int LEAF_BIT = 0;
  localparam int SPACE_SEL_BIT = 1;
  localparam int TTL_LSB = 8;
  localparam int GRANULE_HINT_LSB = 10;
  localparam int ADDR_LO_LSB = 12;
  localparam int ADDR_LO_W = 20;
  localparam int ADDR_HI_W = 20;
  localparam int RSV_ADDR_W = 4;
  localparam int PAGE_W = 40;
  localparam logic [5:0] PAGE_SHIFT = 6'h0C;

  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_VALID = 8'h08;
  localparam logic [7:0] REG_ILL_COUNT = 8'h0C;

  // control register fields and reset value
  localparam int CTRL_S2_BIT = 0;
  localparam int CTRL_SEC_S2_BIT = 1;
  localparam int CTRL_RANGE_BIT = 2;
  localparam int CTRL_IAS_LSB = 8;
  localparam int CTRL_IAS_W = 6;
  localparam logic [31:0] CTRL_RST = 32'h0000_3003;
  localparam logic [31:0] CTRL_MASK = 32'h0000_3F07;

  // status register fields
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_OP_LSB = 8;
  localparam int STAT_DONE_LSB = 16;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  typedef enum logic [1:0] {
    KIND_VA = 2'b00,
    KIND_S2 = 2'b01,
    KIND_NEST = 2'b10
  } sti_kind_t;

  typedef enum logic [1:0] {
    SC_NONE = 2'b00,
    SC_ADDR = 2'b01,
    SC_VM = 2'b10,
    SC_ALL = 2'b11
  } sti_scope_kind_t;

  typedef struct packed {
    logic valid;
    logic secure;
    logic hyp;
    sti_kind_t kind;
    logic last;
    logic space_sel;
    logic [15:0] virtual_machine_tag;
    logic [39:0] gpa_page;
  } sti_entry_t;

  typedef struct packed {
    sti_scope_kind_t kind;
    logic secure;
    logic leaf;
    logic space_sel;
    logic [15:0] virtual_machine_tag;
    logic [39:0] gpa_page;
  } sti_scope_t;

  typedef struct packed {
    logic [31:0] w3;
    logic [31:0] w2;
    logic [31:0] w1;
    logic [31:0] w0;
  } sti_cmd_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } sti_bus_t;
endpackage

// ===== hdl/sti_match.sv
// one cache entry compared against the scope of an invalidation
`timescale 1ns/1ns
module sti_match (
  input wire sti_pkg::sti_entry_t i_entry,
  input wire sti_pkg::sti_scope_t i_scope,
  output logic o_hit
);
  wire tag_eq = i_entry.virtual_machine_tag == i_scope.virtual_machine_tag;
  // hypervisor entries are never touched by these commands
  wire regime_eq = i_entry.valid & ~i_entry.hyp & (i_entry.secure == i_scope.secure);
  // only stage-2-only entries are tagged as guest-physical; nested ones are left by the address form
  wire is_gpa = i_entry.kind == sti_pkg::KIND_S2;
  wire page_eq = i_entry.gpa_page == i_scope.gpa_page;
  wire leaf_ok = ~i_scope.leaf | i_entry.last;
  wire space_ok = ~i_scope.secure | (i_entry.space_sel == i_scope.space_sel);
  wire addr_hit = is_gpa & tag_eq & page_eq & leaf_ok & space_ok;
  wire vm_hit = (i_scope.kind == sti_pkg::SC_VM) & tag_eq;
  wire all_hit = i_scope.kind == sti_pkg::SC_ALL;
  wire sel_addr = (i_scope.kind == sti_pkg::SC_ADDR) & addr_hit;

  assign o_hit = regime_eq & (all_hit | vm_hit | sel_addr);
endmodule

// ===== hdl/sti_core.sv
// command decode and cache invalidation for stage 2 and common commands
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
module sti_core #(
  parameter int DEPTH = 16,
  parameter logic [7:0] OP_VM_ALL = 8'h2C,
  parameter logic [7:0] OP_SEC_VM_ALL = 8'h5C,
  parameter logic [7:0] OP_SEC_ALL = 8'h60,
  parameter bit RSV_HI_ADDR = 1'b1
) (
  input wire i_clk,
  input wire i_rst_b,
  input wire i_cmd_valid,
  input wire sti_pkg::sti_cmd_t i_cmd,
  input wire i_cmd_secure_q,
  output logic o_cmd_ready,
  output logic o_inv_done,
  output logic o_illegal_command_error,
  output logic o_unhandled,
  input wire i_fill_valid,
  input wire [$clog2(DEPTH)-1:0] i_fill_idx,
  input wire sti_pkg::sti_entry_t i_fill_entry,
  output logic [DEPTH-1:0] o_valid_mask,
  input wire sti_pkg::sti_bus_t i_bus,
  output logic [31:0] o_reg_rdata
);
  localparam int IDX_W = $clog2(DEPTH);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] ctrl;
  logic err;
  logic [7:0] last_op;
  logic [15:0] done_cnt;
  logic [15:0] ill_cnt;
  logic done_q;
  logic ill_q;
  logic unh_q;
  sti_pkg::sti_entry_t entry [DEPTH];
  logic [DEPTH-1:0] hit;
  logic [DEPTH-1:0] sec_vec;
  logic [DEPTH-1:0] hyp_vec;
  logic [DEPTH-1:0] sel_vec;
  logic [DEPTH-1:0] s2_vec;

  ////////////////////////////////////////////////////////////////////////
  // capabilities from the control register
  wire cap_s2 = ctrl[sti_pkg::CTRL_S2_BIT];
  wire cap_sec_s2 = ctrl[sti_pkg::CTRL_SEC_S2_BIT];
  wire range_en = ctrl[sti_pkg::CTRL_RANGE_BIT];
  wire [5:0] input_address_size = ctrl[sti_pkg::CTRL_IAS_LSB +: sti_pkg::CTRL_IAS_W];

  ////////////////////////////////////////////////////////////////////////
  // opcode decode; fields outside the layout are never looked at
  wire [7:0] opcode = i_cmd.w0[sti_pkg::OPCODE_LSB +: sti_pkg::OPCODE_W];
  wire is_s2_addr = opcode == sti_pkg::OP_S2_ADDR;
  wire is_vm_all = opcode == OP_VM_ALL;
  wire is_ns_all = opcode == sti_pkg::OP_NS_ALL;
  wire is_sec_addr = opcode == sti_pkg::OP_SEC_S2_ADDR;
  wire is_sec_vm = opcode == OP_SEC_VM_ALL;
  wire is_sec_all = opcode == OP_SEC_ALL;
  wire sec_op = is_sec_addr | is_sec_vm | is_sec_all;
  wire addr_op = is_s2_addr | is_sec_addr;
  wire vm_op = is_vm_all | is_sec_vm;
  wire mine = is_s2_addr | is_vm_all | is_ns_all | sec_op;

  // the queue of origin matters only for the secure forms
  wire ill_no_s2 = (is_s2_addr | is_vm_all) & ~cap_s2;
  wire ill_nonsec_q = sec_op & ~i_cmd_secure_q;
  wire ill_no_sec_s2 = sec_op & ~cap_sec_s2;
  // the non-secure all-entries form has no capability check at all
  wire ill_cmd = ill_no_s2 | ill_nonsec_q | ill_no_sec_s2;
  wire take = i_cmd_valid & mine;
  wire ill_ev = take & ill_cmd;
  wire ok_ev = take & ~ill_cmd;

  ////////////////////////////////////////////////////////////////////////
  // address parameter: only bits 51..12 are read, so bits 11..0 act as zero
  wire [19:0] addr_lo = i_cmd.w2[sti_pkg::ADDR_LO_LSB +: sti_pkg::ADDR_LO_W];
  wire [15:0] addr_hi_keep = i_cmd.w3[15:0];
  wire [3:0] addr_rsv_in = i_cmd.w3[16 +: sti_pkg::RSV_ADDR_W];
  wire [3:0] addr_rsv = RSV_HI_ADDR ? 4'h0 : addr_rsv_in;
  wire [39:0] gpa_page = {addr_rsv, addr_hi_keep, addr_lo};
  // granule and level hints are decoded but this cache keys on page only
  wire [1:0] granule_hint = i_cmd.w2[sti_pkg::GRANULE_HINT_LSB +: 2];
  wire [1:0] level_hint = i_cmd.w2[sti_pkg::TTL_LSB +: 2];
  wire leaf = i_cmd.w2[sti_pkg::LEAF_BIT];
  wire sel_bit = i_cmd.w2[sti_pkg::SPACE_SEL_BIT];
  // selector is meaningful only for the secure address form
  wire space_sel = is_sec_addr ? sel_bit : 1'b1;
  wire [15:0] vm_tag = i_cmd.w1[sti_pkg::VM_TAG_LSB +: sti_pkg::VM_TAG_W];

  // out-of-range check is optional; an out-of-range address removes nothing
  wire [5:0] range_sh = input_address_size - sti_pkg::PAGE_SHIFT;
  wire [39:0] range_mask = {40{1'b1}} << range_sh;
  wire out_of_range = range_en & (|(gpa_page & range_mask));

  ////////////////////////////////////////////////////////////////////////
  // invalidation scope handed to every entry comparator
  sti_pkg::sti_scope_t scope;
  sti_pkg::sti_scope_kind_t scope_kind;
  wire addr_kind_ok = addr_op & ~out_of_range;

  assign scope_kind = ~ok_ev ? sti_pkg::SC_NONE :
                      addr_kind_ok ? sti_pkg::SC_ADDR :
                      addr_op ? sti_pkg::SC_NONE :
                      vm_op ? sti_pkg::SC_VM :
                      sti_pkg::SC_ALL;
  assign scope.kind = scope_kind;
  assign scope.secure = sec_op;
  assign scope.leaf = leaf;
  assign scope.space_sel = space_sel;
  assign scope.virtual_machine_tag = vm_tag;
  assign scope.gpa_page = gpa_page;

  ////////////////////////////////////////////////////////////////////////
  // cache entries
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_ent
      sti_match u_match (
        .i_entry(entry[gi]),
        .i_scope(scope),
        .o_hit(hit[gi])
      );
      assign o_valid_mask[gi] = entry[gi].valid;
      assign sec_vec[gi] = entry[gi].secure;
      assign hyp_vec[gi] = entry[gi].hyp;
      assign sel_vec[gi] = entry[gi].space_sel;
      assign s2_vec[gi] = entry[gi].kind == sti_pkg::KIND_S2;
    end
  endgenerate

  // an invalidation beats a fill to the same slot: the fill may be stale
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        entry[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (hit[i]) begin
          entry[i].valid <= 1'b0;
        end else if (i_fill_valid && i_fill_idx == IDX_W'(i)) begin
          entry[i] <= i_fill_entry;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command answers, one cycle after the command
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_q <= 1'b0;
      ill_q <= 1'b0;
      unh_q <= 1'b0;
    end else begin
      done_q <= ok_ev;
      ill_q <= ill_ev;
      unh_q <= i_cmd_valid & ~mine;
    end
  end

  assign o_cmd_ready = 1'b1;
  assign o_inv_done = done_q;
  assign o_illegal_command_error = ill_q;
  assign o_unhandled = unh_q;

  ////////////////////////////////////////////////////////////////////////
  // register port
  wire wr_ctrl = i_bus.wr & (i_bus.addr == sti_pkg::REG_CTRL);
  wire wr_status = i_bus.wr & (i_bus.addr == sti_pkg::REG_STATUS);
  wire err_clr = wr_status & i_bus.wdata[sti_pkg::STAT_ERR_BIT];
  // a new error in the clearing cycle keeps the flag set
  wire next_err = ill_ev | (err & ~err_clr);
  wire [31:0] next_ctrl = wr_ctrl ? (i_bus.wdata & sti_pkg::CTRL_MASK) : ctrl;
  wire [7:0] next_last_op = ill_ev ? opcode : last_op;
  wire [15:0] next_done_cnt = ok_ev ? done_cnt + 16'h0001 : done_cnt;
  wire [15:0] next_ill_cnt = ill_ev ? ill_cnt + 16'h0001 : ill_cnt;

  wire [31:0] rd_status = {done_cnt, last_op, 7'h00, err};
  wire [31:0] rd_valid = 32'(o_valid_mask);
  wire [31:0] rd_ill = {16'h0000, ill_cnt};
  wire [31:0] rd_sel = (i_bus.addr == sti_pkg::REG_CTRL) ? ctrl :
                       (i_bus.addr == sti_pkg::REG_STATUS) ? rd_status :
                       (i_bus.addr == sti_pkg::REG_VALID) ? rd_valid :
                       (i_bus.addr == sti_pkg::REG_ILL_COUNT) ? rd_ill :
                       32'h0000_0000;
  wire [31:0] next_rdata = i_bus.rd ? rd_sel : 32'h0000_0000;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl <= sti_pkg::CTRL_RST;
      err <= 1'b0;
      last_op <= 8'h00;
      done_cnt <= sti_pkg::COUNT_RST;
      ill_cnt <= sti_pkg::COUNT_RST;
      o_reg_rdata <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      err <= next_err;
      last_op <= next_last_op;
      done_cnt <= next_done_cnt;
      ill_cnt <= next_ill_cnt;
      o_reg_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks on the answers, the scope and the hit vector; those on a single slot use slot 0, which stands for every slot
  wire fill0 = i_fill_valid & (i_fill_idx == '0);
  wire e0_ns = entry[0].valid & ~entry[0].hyp & ~entry[0].secure;
  wire e0_sec = entry[0].valid & ~entry[0].hyp & entry[0].secure;
  wire e0_tag = entry[0].virtual_machine_tag == vm_tag;
  wire e0_page = entry[0].gpa_page == gpa_page;
  // a fill into slot 0 in the same cycle would hide a kept entry
  wire keep0 = entry[0].valid & ~fill0;

  a_ill_no_stage2: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & (is_s2_addr | is_vm_all) & ~cap_s2 |=> o_illegal_command_error & ~o_inv_done)
    else $error("stage 2 command without stage 2 not flagged");

  a_ill_nonsec_queue: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & sec_op & ~i_cmd_secure_q |=> o_illegal_command_error & ~o_inv_done)
    else $error("secure command from non-secure queue not flagged");

  a_ill_no_secure: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & sec_op & ~cap_sec_s2 |=> o_illegal_command_error)
    else $error("secure command without secure stage 2 not flagged");

  a_all_always_legal: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & is_ns_all |=> o_inv_done & ~o_illegal_command_error)
    else $error("non-secure all-entries command refused");

  a_queue_blind: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & (is_s2_addr | is_vm_all) & cap_s2 |=> o_inv_done & ~o_illegal_command_error)
    else $error("non-secure stage 2 command depends on queue");

  a_vm_all_clears: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & is_vm_all & cap_s2 & e0_ns & e0_tag |=> ~entry[0].valid)
    else $error("vm-wide invalidation left a matching entry");

  a_all_keeps_hyp: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & is_ns_all & entry[0].valid & entry[0].hyp & ~fill0 |=> entry[0].valid)
    else $error("all-entries invalidation removed a hypervisor entry");

  a_sec_all_clears: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & is_sec_all & ~ill_cmd & e0_sec |=> ~entry[0].valid & o_inv_done)
    else $error("secure all-entries invalidation left an entry");

  a_leaf_keeps_upper: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & addr_op & leaf & entry[0].valid & ~entry[0].last & ~fill0 & ~sec_op |=> entry[0].valid)
    else $error("leaf invalidation removed a non-leaf entry");

  a_addr_clears: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & is_s2_addr & cap_s2 & ~out_of_range & e0_ns & e0_tag & e0_page
    & (entry[0].kind == sti_pkg::KIND_S2) & (~leaf | entry[0].last) |=> ~entry[0].valid)
    else $error("address invalidation left a stage-2-only entry");

  a_nested_kept: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & addr_op & entry[0].valid & (entry[0].kind != sti_pkg::KIND_S2) & ~fill0 |=> entry[0].valid)
    else $error("address invalidation removed a non guest-physical entry");

  a_rsv_addr_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    RSV_HI_ADDR & i_cmd_valid |-> scope.gpa_page[39:36] == 4'h0)
    else $error("reserved address bits reached the comparators");

  a_range_no_hit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & addr_op & out_of_range |-> ~|hit)
    else $error("out-of-range address removed an entry");

  a_ns_keeps_secure: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & ~sec_op |-> ~|(hit & sec_vec))
    else $error("non-secure command hit a secure entry");

  a_sec_keeps_ns: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & sec_op |-> ~|(hit & ~sec_vec))
    else $error("secure command hit a non-secure entry");

  a_hyp_kept: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid |-> ~|(hit & hyp_vec))
    else $error("invalidation hit a hypervisor entry");

  a_ill_no_hit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ill_ev |-> ~|hit)
    else $error("illegal command removed an entry");

  a_unknown_no_hit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & ~mine |-> ~|hit ##1 (o_unhandled & ~o_inv_done & ~o_illegal_command_error))
    else $error("unknown opcode changed the cache or gave a wrong answer");

  a_sec_addr_sel: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & is_sec_addr |-> ~|(hit & (sel_vec ^ {DEPTH{sel_bit}})))
    else $error("secure address invalidation hit the other address space");

  a_addr_s2_only: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & addr_op |-> ~|(hit & ~s2_vec))
    else $error("address invalidation hit a non guest-physical entry");

  a_vm_keeps_other: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & is_vm_all & keep0 & ~e0_tag |=> entry[0].valid)
    else $error("vm-wide invalidation removed another tag");

  a_ns_all_clears: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & is_ns_all & e0_ns |=> ~entry[0].valid & o_inv_done)
    else $error("all-entries invalidation left a non-secure entry");

  a_one_answer: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_cmd_valid & mine |=> (o_inv_done ^ o_illegal_command_error) & ~o_unhandled)
    else $error("handled command did not give exactly one answer");

  a_err_set_wins: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    ill_ev |=> err)
    else $error("illegal command did not set the sticky error");

  c_illegal: cover property (@(posedge i_clk) disable iff (!i_rst_b) o_illegal_command_error);
  c_addr_hit: cover property (@(posedge i_clk) disable iff (!i_rst_b) (scope_kind == sti_pkg::SC_ADDR) & (|hit));
  c_sec_vm_hit: cover property (@(posedge i_clk) disable iff (!i_rst_b) is_sec_vm & (|hit));
  c_all_back: cover property (@(posedge i_clk) disable iff (!i_rst_b) ok_ev & is_ns_all ##1 ok_ev);
  c_range_drop: cover property (@(posedge i_clk) disable iff (!i_rst_b) ok_ev & addr_op & out_of_range);
endmodule

// ===== testbench/sti_sw_model.sv
// software model posting commands into the secure or non-secure command queue
`timescale 1ns/1ns
module sti_sw_model (
  input wire i_clk,
  output logic o_cmd_valid,
  output sti_pkg::sti_cmd_t o_cmd,
  output logic o_cmd_secure_q
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
    o_cmd_secure_q = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one command per call, held over exactly one taking edge
  task automatic post(input sti_pkg::sti_cmd_t c, input logic sq, input logic rsv_ok);
    // real software keeps the reserved top address bits clear, a test may not
    if (!rsv_ok) begin
      c.w3[19:16] = 4'h0;
    end
    @(posedge i_clk);
    o_cmd_valid <= 1'b1;
    o_cmd <= c;
    o_cmd_secure_q <= sq;
    @(posedge i_clk);
    o_cmd_valid <= 1'b0;
    // released lines show the inverse so stale words cannot pass for a command
    o_cmd <= ~c;
    o_cmd_secure_q <= ~sq;
  endtask

  // non-secure driver start-up: its own full flush, never trusting secure code
  task automatic boot_flush();
    sti_pkg::sti_cmd_t c;
    c = '0;
    c.w0[7:0] = sti_pkg::OP_NS_ALL;
    post(c, 1'b0, 1'b0);
  endtask
endmodule

// ===== testbench/tb.sv
// self-checking bench for the stage 2 invalidation core
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [7:0] op;
    logic sq;
    logic [15:0] tag;
    logic leaf;
    logic sel;
    logic hi;
    logic [7:0] mask;
    logic [2:0] res;
  } sti_tb_row_t;

  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic cmd_valid;
  logic cmd_sq;
  sti_pkg::sti_cmd_t cmd;
  logic fill_valid = 1'b0;
  logic [3:0] fill_idx = 4'h0;
  sti_pkg::sti_entry_t fill_entry = '0;
  sti_pkg::sti_bus_t bus = '0;
  logic ready;
  logic done;
  logic ill;
  logic unh;
  logic [15:0] vmask;
  logic [31:0] rdata;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;

  // slots: 0 leaf s2, 1 non-leaf s2, 2 other page, 3 nested, 4 hyp, 5/6 secure sel 0/1, 7 va tag 6
  sti_pkg::sti_entry_t ents [8] = '{
    '{1'b1, 1'b0, 1'b0, sti_pkg::KIND_S2, 1'b1, 1'b0, 16'h0005, 40'h00_0000_0100},
    '{1'b1, 1'b0, 1'b0, sti_pkg::KIND_S2, 1'b0, 1'b0, 16'h0005, 40'h00_0000_0100},
    '{1'b1, 1'b0, 1'b0, sti_pkg::KIND_S2, 1'b1, 1'b0, 16'h0005, 40'h00_0000_0101},
    '{1'b1, 1'b0, 1'b0, sti_pkg::KIND_NEST, 1'b1, 1'b0, 16'h0005, 40'h00_0000_0100},
    '{1'b1, 1'b0, 1'b1, sti_pkg::KIND_S2, 1'b1, 1'b0, 16'h0005, 40'h00_0000_0100},
    '{1'b1, 1'b1, 1'b0, sti_pkg::KIND_S2, 1'b1, 1'b0, 16'h0005, 40'h00_0000_0100},
    '{1'b1, 1'b1, 1'b0, sti_pkg::KIND_S2, 1'b1, 1'b1, 16'h0005, 40'h00_0000_0100},
    '{1'b1, 1'b0, 1'b0, sti_pkg::KIND_VA, 1'b1, 1'b0, 16'h0006, 40'h00_0000_0100}
  };

  // op, secure queue, tag, leaf, selector, junk bits, mask after, result {unhandled, illegal, done}
  sti_tb_row_t rows [15] = '{
    '{8'h2A, 1'b0, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hFC, 3'h1},
    '{8'h2A, 1'b1, 16'h0005, 1'b1, 1'b0, 1'b0, 8'hFE, 3'h1},
    '{8'h2A, 1'b0, 16'h0005, 1'b0, 1'b0, 1'b1, 8'hFC, 3'h1},
    '{8'h2C, 1'b0, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hF0, 3'h1},
    '{8'h2C, 1'b1, 16'h0006, 1'b0, 1'b0, 1'b0, 8'h7F, 3'h1},
    '{8'h5A, 1'b1, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hDF, 3'h1},
    '{8'h5A, 1'b1, 16'h0005, 1'b0, 1'b1, 1'b0, 8'hBF, 3'h1},
    '{8'h5A, 1'b0, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hFF, 3'h2},
    '{8'h5C, 1'b1, 16'h0005, 1'b0, 1'b0, 1'b0, 8'h9F, 3'h1},
    '{8'h5C, 1'b0, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hFF, 3'h2},
    '{8'h30, 1'b0, 16'h0005, 1'b0, 1'b0, 1'b0, 8'h70, 3'h1},
    '{8'h30, 1'b1, 16'h0005, 1'b0, 1'b0, 1'b0, 8'h70, 3'h1},
    '{8'h60, 1'b1, 16'h0005, 1'b0, 1'b0, 1'b0, 8'h9F, 3'h1},
    '{8'h60, 1'b0, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hFF, 3'h2},
    '{8'h22, 1'b1, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hFF, 3'h4}
  };

  sti_core u_sti_core (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_cmd_valid(cmd_valid),
    .i_cmd(cmd),
    .i_cmd_secure_q(cmd_sq),
    .o_cmd_ready(ready),
    .o_inv_done(done),
    .o_illegal_command_error(ill),
    .o_unhandled(unh),
    .i_fill_valid(fill_valid),
    .i_fill_idx(fill_idx),
    .i_fill_entry(fill_entry),
    .o_valid_mask(vmask),
    .i_bus(bus),
    .o_reg_rdata(rdata)
  );

  sti_sw_model u_sti_sw_model (
    .i_clk(i_clk),
    .o_cmd_valid(cmd_valid),
    .o_cmd(cmd),
    .o_cmd_secure_q(cmd_sq)
  );

  always #20 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // a fixed ceiling well above the roughly 480 cycles the run needs
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge i_clk);
    bus <= '0;
    #1;
    check(rdata, exp);
  endtask

  task automatic fill(input int i, input sti_pkg::sti_entry_t e);
    @(posedge i_clk);
    fill_valid <= 1'b1;
    fill_idx <= i[3:0];
    fill_entry <= e;
    @(posedge i_clk);
    fill_valid <= 1'b0;
  endtask

  // refill the eight slots, post one command, then check the valid mask and the one-cycle answer
  task automatic run(input sti_tb_row_t r);
    sti_pkg::sti_cmd_t c;
    for (int i = 0; i < 8; i++) begin
      fill(i, ents[i]);
    end
    c = '0;
    c.w0[7:0] = r.op;
    c.w1 = {16'hA5A5, r.tag};
    c.w2 = {20'h00100, {4{r.hi}}, 6'h00, r.sel, r.leaf};
    c.w3 = {12'h000, {4{r.hi}}, 16'h0000};
    u_sti_sw_model.post(c, r.sq, r.hi);
    #1;
    check({16'h0, vmask}, {24'h0, r.mask});
    check({29'h0, unh, ill, done}, {29'h0, r.res});
    @(posedge i_clk);
    #1;
    check({29'h0, unh, ill, done}, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    rd(8'h00, 32'h0000_3003);
    rd(8'h08, 32'h0);
    rd(8'h10, 32'h0);
    check({31'h0, ready}, 32'h1);
    u_sti_sw_model.boot_flush();
    #1;
    check({31'h0, done}, 32'h1);
    for (int i = 0; i < 15; i++) begin
      run(rows[i]);
    end
    rd(8'h08, 32'h0000_00FF);
    rd(8'h04, 32'h000C_6001);
    rd(8'h0C, 32'h0000_0003);
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h000C_6000);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0000_3F07);
    wr(8'h00, 32'h0000_3002);
    run('{8'h2A, 1'b0, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hFF, 3'h2});
    run('{8'h2C, 1'b1, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hFF, 3'h2});
    run('{8'h30, 1'b1, 16'h0005, 1'b0, 1'b0, 1'b0, 8'h70, 3'h1});
    wr(8'h00, 32'h0000_3001);
    run('{8'h5A, 1'b1, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hFF, 3'h2});
    run('{8'h5C, 1'b1, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hFF, 3'h2});
    run('{8'h60, 1'b1, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hFF, 3'h2});
    // input size 20: page bit 8 is out of range, so nothing goes; size 21 takes it
    wr(8'h00, 32'h0000_1405);
    run('{8'h2A, 1'b0, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hFF, 3'h1});
    wr(8'h00, 32'h0000_1505);
    run('{8'h2A, 1'b0, 16'h0005, 1'b0, 1'b0, 1'b0, 8'hFC, 3'h1});
    // reset in mid-run must drop every slot and restore the control value
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    check({16'h0, vmask}, 32'h0);
    @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    rd(8'h00, 32'h0000_3003);
    rd(8'h0C, 32'h0);
    rd(8'h04, 32'h0);
    close_out();
  end
endmodule
